/* core/byte_lane.v */
// byte lane pick and merge for a 16-bit memory word
`timescale 1ns/10ps
`default_nettype none
`include "xmove_defines.vh"

module byte_lane (
  input wire [15:0] word_i,
  input wire lane_i,
  input wire [7:0] byte_i,
  output wire [7:0] pick_o,
  output wire [15:0] merge_o
);

  // even byte address is the high half of the word
  assign pick_o = (lane_i == `LANE_HIGH) ?
    word_i[`LANE_HI_MSB:`LANE_HI_LSB] :
    word_i[`LANE_LO_MSB:`LANE_LO_LSB];

  // the other lane is passed through untouched
  assign merge_o = (lane_i == `LANE_HIGH) ?
    {byte_i, word_i[`LANE_LO_MSB:`LANE_LO_LSB]} :
    {word_i[`LANE_HI_MSB:`LANE_HI_LSB], byte_i};

endmodule
`default_nettype wire

/* core/cross_map_byte_move.v */
// cross-map byte block move engine
`timescale 1ns/10ps
`default_nettype none
`include "xmove_defines.vh"

module cross_map_byte_move (
  input wire CLK_I,
  input wire SRST_I,
  input wire START_I,
  input wire [15:0] OPCODE_I,
  input wire [15:0] ACC1_I,
  input wire [15:0] ACC2_I,
  input wire [15:0] INDEX_I,
  input wire [15:0] BASE_I,
  input wire CODE_DATA_SPLIT_MODE_I,
  input wire INTR_PENDING_I,
  input wire MEM_ACK_I,
  input wire [15:0] MEM_RDATA_I,
  output reg MEM_REQ_O,
  output reg MEM_WE_O,
  output reg [1:0] MEM_MAP_O,
  output reg [14:0] MEM_ADDR_O,
  output reg [15:0] MEM_WDATA_O,
  output reg BUSY_O,
  output reg DONE_O,
  output reg INTERRUPTED_O,
  output reg NOT_DECODED_O,
  output reg [15:0] ACC1_O,
  output reg [15:0] ACC2_O,
  output reg [15:0] INDEX_O
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // table position: 0 for cur-cur, 1..8 for the others, 9 = no hit
  function [3:0] move_index;
    input [15:0] op;
    begin
      if (op[`XM_FAMILY_HI:`XM_FAMILY_LO] != `XM_FAMILY_CODE) begin
        move_index = 4'h9;
      end else if (op[`XM_SEL_HI:`XM_SEL_LO] == `XM_SEL_CUR_CUR) begin
        move_index = 4'h0;
      end else if (op[`XM_SEL_HI:`XM_SEL_LO] >= `XM_SEL_FIRST_X) begin
        move_index = {1'b0, op[2:0]} + 4'h1;
      end else begin
        move_index = 4'h9;
      end
    end
  endfunction

  // source map is index / 3, destination map is index mod 3
  function [1:0] src_map_of;
    input [3:0] idx;
    begin
      if (idx < 4'h3) begin
        src_map_of = `MAP_CUR;
      end else if (idx < 4'h6) begin
        src_map_of = `MAP_ALT1;
      end else begin
        src_map_of = `MAP_ALT2;
      end
    end
  endfunction

  function [1:0] dst_map_of;
    input [3:0] idx;
    reg [3:0] r;
    begin
      r = idx;
      if (r >= 4'h6) begin
        r = r - 4'h6;
      end else if (r >= 4'h3) begin
        r = r - 4'h3;
      end
      dst_map_of = r[1:0];
    end
  endfunction

  // a current-map address in the base window under split mode is
  // base-relative; other maps behave as non-split
  function is_relative;
    input split;
    input [1:0] map;
    input [15:0] byte_addr;
    reg [14:0] w;
    begin
      w = byte_addr[15:1];
      is_relative = split && (map == `MAP_CUR) &&
        (w >= `BASE_WIN_LO) && (w <= `BASE_WIN_HI);
    end
  endfunction

  // word address on the memory port, with base added when relative
  function [14:0] word_addr;
    input [15:0] byte_addr;
    input rel;
    input [15:0] base;
    begin
      if (rel) begin
        word_addr = byte_addr[15:1] + base[14:0];
      end else begin
        word_addr = byte_addr[15:1];
      end
    end
  endfunction

  // ****************************************************************
  // state and data path
  // ****************************************************************

  reg [2:0] state;
  reg [1:0] src_map;
  reg [1:0] dst_map;
  reg src_rel;
  reg dst_rel;
  reg [15:0] base;
  wire [3:0] start_idx;
  wire [1:0] start_src;
  wire [1:0] start_dst;
  wire [7:0] src_byte;
  wire [15:0] merged_word;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  wire buf_push;
  wire buf_pop;

  assign start_idx = move_index(OPCODE_I);
  assign start_src = src_map_of(start_idx);
  assign start_dst = dst_map_of(start_idx);

  // the buffer takes a byte when the source read lands and frees it
  // only when the merged destination write is acknowledged
  assign buf_push = (state == `ST_RD_SRC) && MEM_ACK_I;
  assign buf_pop = (state == `ST_WR_DST) && MEM_ACK_I;

  // lane pick from the source word
  byte_lane u_src_lane (
    .word_i(MEM_RDATA_I),
    .lane_i(ACC1_O[`LANE_BIT]),
    .byte_i(8'h00),
    .pick_o(src_byte),
    .merge_o()
  );

  // lane merge into the destination word
  byte_lane u_dst_lane (
    .word_i(MEM_RDATA_I),
    .lane_i(ACC2_O[`LANE_BIT]),
    .byte_i(buf_out_data),
    .pick_o(),
    .merge_o(merged_word)
  );

  // holds the byte between its read and its write
  pair_buffer #(
    .WIDTH(8),
    .DEPTH(2),
    .AW(1)
  ) u_buf (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .in_valid_i(buf_push),
    .in_ready_o(buf_in_ready),
    .in_data_i(src_byte),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************

  // one byte per loop: read source, read destination, write merged
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      state <= `ST_IDLE;
      src_map <= `MAP_CUR;
      dst_map <= `MAP_CUR;
      src_rel <= 1'b0;
      dst_rel <= 1'b0;
      base <= 16'h0000;
      MEM_REQ_O <= 1'b0;
      MEM_WE_O <= 1'b0;
      MEM_MAP_O <= `MAP_CUR;
      MEM_ADDR_O <= 15'h0000;
      MEM_WDATA_O <= 16'h0000;
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
      INTERRUPTED_O <= 1'b0;
      NOT_DECODED_O <= 1'b0;
      ACC1_O <= 16'h0000;
      ACC2_O <= 16'h0000;
      INDEX_O <= 16'h0000;
    end else begin
      DONE_O <= 1'b0;
      INTERRUPTED_O <= 1'b0;
      NOT_DECODED_O <= 1'b0;
      case (state)
        `ST_IDLE: begin
          if (START_I && start_idx == 4'h9) begin
            NOT_DECODED_O <= 1'b1;
          end else if (START_I) begin
            // relativity is judged once, before any byte moves
            ACC1_O <= ACC1_I;
            ACC2_O <= ACC2_I;
            INDEX_O <= INDEX_I;
            base <= BASE_I;
            src_map <= start_src;
            dst_map <= start_dst;
            src_rel <= is_relative(CODE_DATA_SPLIT_MODE_I, start_src,
              ACC1_I);
            dst_rel <= is_relative(CODE_DATA_SPLIT_MODE_I, start_dst,
              ACC2_I);
            BUSY_O <= 1'b1;
            state <= `ST_RUN;
          end
        end
        `ST_RUN: begin
          if (INDEX_O == 16'h0000) begin
            state <= `ST_FINISH;
          end else if (INTR_PENDING_I) begin
            // progress lives only in the three registers
            BUSY_O <= 1'b0;
            INTERRUPTED_O <= 1'b1;
            state <= `ST_IDLE;
          end else if (buf_in_ready) begin
            MEM_REQ_O <= 1'b1;
            MEM_WE_O <= 1'b0;
            MEM_MAP_O <= src_map;
            MEM_ADDR_O <= word_addr(ACC1_O, src_rel, base);
            state <= `ST_RD_SRC;
          end
        end
        `ST_RD_SRC: begin
          if (MEM_ACK_I) begin
            ACC1_O <= ACC1_O + 16'h0001;
            MEM_MAP_O <= dst_map;
            MEM_ADDR_O <= word_addr(ACC2_O, dst_rel, base);
            state <= `ST_RD_DST;
          end
        end
        `ST_RD_DST: begin
          if (MEM_ACK_I && buf_out_valid) begin
            // write-back keeps the untouched lane intact
            MEM_WE_O <= 1'b1;
            MEM_WDATA_O <= merged_word;
            state <= `ST_WR_DST;
          end
        end
        `ST_WR_DST: begin
          if (MEM_ACK_I) begin
            MEM_REQ_O <= 1'b0;
            MEM_WE_O <= 1'b0;
            ACC2_O <= ACC2_O + 16'h0001;
            INDEX_O <= INDEX_O - 16'h0001;
            state <= `ST_RUN;
          end
        end
        `ST_FINISH: begin
          // relative registers were never rebased, so they exit relative
          BUSY_O <= 1'b0;
          DONE_O <= 1'b1;
          state <= `ST_IDLE;
        end
        default: begin
          MEM_REQ_O <= 1'b0;
          MEM_WE_O <= 1'b0;
          BUSY_O <= 1'b0;
          state <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* core/pair_buffer.v */
// small valid/ready buffer holding bytes in flight
`timescale 1ns/10ps
`default_nettype none

module pair_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire clk_i,
  input wire srst_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] fill;
  wire push;
  wire pop;

  // full and empty come straight from the fill count
  assign in_ready_o = (fill != DEPTH[AW:0]);
  assign out_valid_o = (fill != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointers wrap at the depth, which need not be a power of two
  always @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

  // storage has no reset, only valid entries are ever read
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule
`default_nettype wire

/* core/xmove_defines.vh */
// constants shared by the cross-map byte move engine
`ifndef XMOVE_DEFINES_VH
`define XMOVE_DEFINES_VH

// opcode layout
`define XM_FAMILY_HI 15
`define XM_FAMILY_LO 5
`define XM_FAMILY_CODE 11'h41e
`define XM_SEL_HI 4
`define XM_SEL_LO 0
`define XM_SEL_CUR_CUR 5'h17
`define XM_SEL_FIRST_X 5'h18

// map codes driven on the memory port
`define MAP_CUR 2'h0
`define MAP_ALT1 2'h1
`define MAP_ALT2 2'h2
`define MAP_COUNT 3

// byte lane inside a word
`define LANE_BIT 0
`define LANE_HIGH 1'h0
`define LANE_HI_MSB 15
`define LANE_HI_LSB 8
`define LANE_LO_MSB 7
`define LANE_LO_LSB 0

// word window that gets the base register added
`define BASE_WIN_LO 15'h0002
`define BASE_WIN_HI 15'h03ff

// engine states
`define ST_IDLE 3'h0
`define ST_RUN 3'h1
`define ST_RD_SRC 3'h2
`define ST_RD_DST 3'h3
`define ST_WR_DST 3'h4
`define ST_FINISH 3'h5

`endif

/* dv/tb.sv */
// self-checking bench for the cross-map byte move engine
`timescale 1ns/10ps
`default_nettype none
`include "xmove_defines.vh"

module tb;
  // *****
  // harness
  // *****
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic start = 1'b0;
  logic code_data_split_mode = 1'b0;
  logic intr = 1'b0;
  logic seen = 1'b0;
  logic [1:0] wt = 2'h0;
  logic [15:0] op = 16'h0, a1 = 16'h0, a2 = 16'h0, x = 16'h0, q = 16'h0;
  wire ack, req, we, busy, done, intd, nd;
  wire [1:0] map;
  wire [14:0] addr;
  wire [15:0] rd, wd, a1o, a2o, xo;
  logic [15:0] exp [0:2][0:2047];
  int fails = 0, comparisons = 0, cyc = 0;
  always #2 clk = ~clk;
  cross_map_byte_move i_dut (.CLK_I(clk), .SRST_I(srst), .START_I(start),
    .OPCODE_I(op), .ACC1_I(a1), .ACC2_I(a2), .INDEX_I(x), .BASE_I(q),
    .CODE_DATA_SPLIT_MODE_I(code_data_split_mode), .INTR_PENDING_I(intr), .MEM_ACK_I(ack),
    .MEM_RDATA_I(rd), .MEM_REQ_O(req), .MEM_WE_O(we), .MEM_MAP_O(map),
    .MEM_ADDR_O(addr), .MEM_WDATA_O(wd), .BUSY_O(busy), .DONE_O(done),
    .INTERRUPTED_O(intd), .NOT_DECODED_O(nd), .ACC1_O(a1o), .ACC2_O(a2o),
    .INDEX_O(xo));
  xmove_mem i_mem (.clk_i(clk), .req_i(req), .we_i(we), .map_i(map),
    .addr_i(addr), .wdata_i(wd), .wait_i(wt), .ack_o(ack), .rdata_o(rd));
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, well above the longest run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end
  // word index as the memory sees it, base added when relative
  function automatic int wi(input logic [15:0] a, input logic r,
    input logic [15:0] b);
    logic [15:0] t;
    t = (a >> 1) + (r ? {1'b0, b[14:0]} : 16'h0);
    return t[10:0];
  endfunction
  task automatic go(input logic [15:0] s, d, n);
    a1 = s;
    a2 = d;
    x = n;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
  endtask
  task automatic wait_end(input int ia);
    int k;
    for (k = 0; k < 3000 && done !== 1'b1 && intd !== 1'b1; k++) begin
      if (k == ia)
        intr = 1'b1;
      @(posedge clk);
      #1;
    end
    // a hang must not slip through as a clean finish
    chk("ended", 16'h1, {15'h0, done | intd});
  endtask
  // one move: preload, predict, run, resume if paused, compare
  task automatic run(input logic [3:0] i, input logic [15:0] s, d, n, b,
    input logic sp, input int ia);
    logic [15:0] w;
    logic [7:0] by;
    logic rs, rt;
    int m, k, bad;
    rs = sp && i < 3 && s[15:1] >= 2 && s[15:1] < 1024;
    rt = sp && i % 3 == 0 && d[15:1] >= 2 && d[15:1] < 1024;
    for (m = 0; m < 3; m++)
      for (k = 0; k < 2048; k++) begin
        w = {k[7:0] ^ 8'h5a, k[10:3] + m[7:0]};
        i_mem.mem[m][k] = w;
        exp[m][k] = w;
      end
    for (k = 0; k < n; k++) begin
      w = exp[i / 3][wi(s + k, rs, b)];
      by = s[0] ^ k[0] ? w[7:0] : w[15:8];
      if (d[0] ^ k[0])
        exp[i % 3][wi(d + k, rt, b)][7:0] = by;
      else
        exp[i % 3][wi(d + k, rt, b)][15:8] = by;
    end
    op = {`XM_FAMILY_CODE, `XM_SEL_CUR_CUR + {1'b0, i}};
    q = b;
    code_data_split_mode = sp;
    go(s, d, n);
    wait_end(ia);
    if (intd === 1'b1) begin
      seen = 1'b1;
      intr = 1'b0;
      chk("part src", s + n - xo, a1o);
      chk("part dst", d + n - xo, a2o);
      go(a1o, a2o, xo);
      wait_end(-1);
    end
    chk("src end", s + n, a1o);
    chk("dst end", d + n, a2o);
    chk("count end", 16'h0, xo);
    bad = 0;
    for (m = 0; m < 3; m++)
      for (k = 0; k < 2048; k++)
        if (i_mem.mem[m][k] !== exp[m][k])
          bad++;
    chk("bad words", 16'h0, bad[15:0]);
  endtask
  // *****
  // scenarios
  // *****
  task t_maps;
    int i;
    logic [15:0] s, d;
    s = 16'h8013;
    d = 16'h4040;
    for (i = 0; i < 9; i++) begin
      wt = i[1:0];
      run(i[3:0], s, d, 16'h5, 16'h0, 1'b0, -1);
    end
    $display("test maps done");
  endtask
  task t_zero;
    run(4'h4, 16'h0010, 16'h0021, 16'h0, 16'h0, 1'b0, -1);
    $display("test zero done");
  endtask
  // foreign select code, then foreign family
  task t_undecoded;
    int k;
    for (k = 0; k < 2; k++) begin
      op = k ? {11'h41f, 5'h17} : {`XM_FAMILY_CODE, 5'h16};
      start = 1'b1;
      @(posedge clk);
      #1 start = 1'b0;
      chk("not decoded", 16'h1, {15'h0, nd});
      chk("busy", 16'h0, {15'h0, busy});
      // let an edge pass so start never toggles twice in one step
      @(posedge clk);
      #1;
    end
    $display("test undecoded done");
  endtask
  task t_split;
    logic [15:0] s, d, b;
    s = 16'h0011;
    d = 16'h0100;
    b = 16'h0400;
    wt = 2'h1;
    run(4'h0, s, d, 16'h4, b, 1'b1, -1);
    run(4'h1, s, d, 16'h4, b, 1'b1, -1);
    run(4'h3, s, d, 16'h4, b, 1'b1, -1);
    run(4'h4, s, d, 16'h4, b, 1'b1, -1);
    run(4'h0, 16'h0002, 16'h0802, 16'h3, b, 1'b1, -1);
    $display("test split done");
  endtask
  task t_intr;
    wt = 2'h0;
    run(4'h0, 16'h0021, 16'h0060, 16'h6, 16'h0, 1'b0, 9);
    chk("paused", 16'h1, {15'h0, seen});
    $display("test interrupt done");
  endtask
  // addresses are kept clear of wrap-around by the stimulus
  initial begin
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    t_maps();
    t_zero();
    t_undecoded();
    t_split();
    t_intr();
    end_of_test();
  end
endmodule

bind cross_map_byte_move xmove_checker i_chk (.CLK_I, .SRST_I, .START_I,
  .OPCODE_I, .ACC1_I, .INDEX_I, .CODE_DATA_SPLIT_MODE_I, .INTR_PENDING_I,
  .MEM_ACK_I, .MEM_REQ_O, .MEM_WE_O, .MEM_ADDR_O, .BUSY_O, .DONE_O,
  .INTERRUPTED_O, .INDEX_O);
`default_nettype wire

/* dv/xmove_checker.sv */
// port-level assertions for the cross-map byte move engine
`timescale 1ns/10ps
`default_nettype none
`include "xmove_defines.vh"

module xmove_checker (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic START_I,
  input wire logic [15:0] OPCODE_I,
  input wire logic [15:0] ACC1_I,
  input wire logic [15:0] INDEX_I,
  input wire logic CODE_DATA_SPLIT_MODE_I,
  input wire logic INTR_PENDING_I,
  input wire logic MEM_ACK_I,
  input wire logic MEM_REQ_O,
  input wire logic MEM_WE_O,
  input wire logic [14:0] MEM_ADDR_O,
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic INTERRUPTED_O,
  input wire logic [15:0] INDEX_O
);
  // *****
  // issue rules
  // *****
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // family match plus a select code the engine knows
  wire logic dec = OPCODE_I[15:5] == `XM_FAMILY_CODE &&
    OPCODE_I[4:0] >= `XM_SEL_CUR_CUR;
  sequence s_go;
    START_I && !BUSY_O && dec;
  endsequence
  sequence s_plain;
    s_go ##0 INDEX_I != 16'h0 && !CODE_DATA_SPLIT_MODE_I;
  endsequence
  a_busy_answer: assert property (s_go |=> BUSY_O)
    else $error("busy not raised");
  a_bad_opcode: assert property (
    START_I && !BUSY_O && !dec |=> !BUSY_O)
    else $error("busy for foreign opcode");
  a_zero_done: assert property (s_go ##0 INDEX_I == 16'h0 |=>
    (!MEM_REQ_O [*2]) ##1 (DONE_O && !MEM_REQ_O)) else $error("zero count");
  a_first_src: assert property (s_plain ##1 !INTR_PENDING_I |=>
    MEM_REQ_O && !MEM_WE_O && {1'b0, MEM_ADDR_O} == $past(ACC1_I, 2) >> 1)
    else $error("first source word wrong");
  // a stalled access must not move under the memory
  a_req_held: assert property (
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O &&
    $stable(MEM_ADDR_O) && $stable(MEM_WE_O)) else $error("request moved");
  a_done_count: assert property (
    DONE_O |-> INDEX_O == 16'h0 && !BUSY_O)
    else $error("done with count left");
  a_intr_stop: assert property (
    INTERRUPTED_O |-> !BUSY_O && !MEM_REQ_O)
    else $error("interrupt left engine busy");
  a_write_req: assert property (MEM_WE_O |-> MEM_REQ_O)
    else $error("write without request");
endmodule
`default_nettype wire

/* dv/xmove_mem.sv */
// memory model behind the three maps, with wait states
`timescale 1ns/10ps
`default_nettype none

module xmove_mem (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [1:0] map_i,
  input wire logic [14:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic [1:0] wait_i,
  output logic ack_o,
  output logic [15:0] rdata_o
);
  // *****
  // storage and ack
  // *****
  logic [15:0] mem [0:2][0:2047];
  logic [1:0] cnt = 2'h0;
  initial ack_o = 1'b0;
  initial rdata_o = 16'h0;
  // read data flips outside its ack so stale values never match
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      cnt <= cnt + 2'h1;
      if (cnt == wait_i) begin
        cnt <= 2'h0;
        ack_o <= 1'b1;
        rdata_o <= mem[map_i][addr_i[10:0]];
        if (we_i)
          mem[map_i][addr_i[10:0]] <= wdata_i;
      end
    end
  end
endmodule
`default_nettype wire
